// ---- hdl/asc_cfg.svh ----
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
`define ASC_ADDR_W 18
// register offsets are word indices; byte address is four times
`define ASC_OFS_FLAGS 16'hFF2A
`define ASC_OFS_CTRL 16'hFF80
`define ASC_OFS_IRQ_MASK 16'hFF84
`define ASC_IDX_HI 17
`define ASC_IDX_LO 2
`define ASC_BIT_DONE 7
`define ASC_BIT_PEN 6
`define ASC_BIT_UPD 5
`define ASC_BIT_START 7
`define ASC_BIT_HAND 4
`define ASC_BIT_REF 3
`define ASC_CHS_HI 2
`define ASC_CHS_LO 0
`define ASC_FLAGS_MASK 8'hE0
`define ASC_CTRL_RMASK 8'h1F
`define ASC_RESP_OKAY 2'h0
`define ASC_RESP_SLVERR 2'h2
`endif

// ---- hdl/asc_pkg.sv ----
package asc_pkg;
	typedef struct packed {
		logic conv_done_flag;
		logic pen_down_flag;
		logic touch_data_update_flag;
	} asc_flags_t;
	typedef struct packed {
		logic ref_handover_enable;
		logic ref_supply_switch;
		logic [2:0] input_channel_select;
	} asc_ctrl_t;
	typedef enum logic [1:0] {
		ASC_W_IDLE,
		ASC_W_RESP
	} asc_wstate_t;
endpackage

// ---- hdl/asc_chan_dec.sv ----
`include "asc_cfg.svh"
module asc_chan_dec
	import asc_pkg::*;
(
	input wire logic [2:0] code_in,
	output logic [7:0] onehot_out
);
	always_comb begin
		onehot_out = 8'h00;
		onehot_out[code_in] = 1'b1;
	end
endmodule

// ---- hdl/asc_ctrl.sv ----
`include "asc_cfg.svh"
module asc_ctrl
	import asc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic [17:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [17:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic conv_done_in,
	input wire logic pen_down_in,
	input wire logic touch_data_update_in,
	input wire logic touch_ref_request_in,
	output logic conv_start_trigger_out,
	output logic [2:0] conv_channel_out,
	output logic [7:0] channel_onehot_out,
	output logic converter_reference_supply_out,
	output logic ref_handover_enable_out,
	output logic irq_out
);
	typedef struct packed {
		asc_flags_t flags;
		asc_flags_t mask;
		asc_ctrl_t ctrl;
		logic start;
		logic [2:0] start_chan;
		logic aw_held;
		logic [17:0] awaddr;
		logic w_held;
		logic [7:0] wdata;
		logic wstrb0;
		asc_wstate_t wst;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
	} asc_state_t;

	asc_state_t st;
	asc_state_t next_st;
	logic do_write;
	logic do_read;
	logic wr_flags;
	logic wr_ctrl;
	logic wr_mask;
	logic [7:0] rd_val;
	logic rd_hit;
	logic [15:0] rd_word;
	logic [15:0] wr_word;

	// bus slave takes aw and w in either order, answers after both
	assign s_axi_awready_out = !st.aw_held && st.wst == ASC_W_IDLE;
	assign s_axi_wready_out = !st.w_held && st.wst == ASC_W_IDLE;
	assign s_axi_bvalid_out = st.wst == ASC_W_RESP;
	assign s_axi_bresp_out = st.bresp;
	assign s_axi_arready_out = !st.rvalid;
	assign s_axi_rvalid_out = st.rvalid;
	assign s_axi_rdata_out = {24'h000000, st.rdata};
	assign s_axi_rresp_out = st.rresp;

	assign do_write = st.aw_held && st.w_held && st.wst == ASC_W_IDLE;
	assign do_read = s_axi_arvalid_in && !st.rvalid;
	// address bits 1:0 ignored; decode on the word index
	assign wr_word = st.awaddr[`ASC_IDX_HI:`ASC_IDX_LO];
	assign rd_word = s_axi_araddr_in[`ASC_IDX_HI:`ASC_IDX_LO];
	// low byte lane only; other lanes hold nothing
	assign wr_flags = do_write && st.wstrb0 &&
		wr_word == `ASC_OFS_FLAGS;
	assign wr_ctrl = do_write && st.wstrb0 && wr_word == `ASC_OFS_CTRL;
	assign wr_mask = do_write && st.wstrb0 && wr_word == `ASC_OFS_IRQ_MASK;

	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		case (rd_word)
			`ASC_OFS_FLAGS: rd_val = {st.flags, 5'h00};
			`ASC_OFS_CTRL: rd_val = {3'h0, st.ctrl};
			`ASC_OFS_IRQ_MASK: rd_val = {st.mask, 5'h00};
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			next_st.aw_held = 1'b1;
			next_st.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			next_st.w_held = 1'b1;
			next_st.wdata = s_axi_wdata_in[7:0];
			next_st.wstrb0 = s_axi_wstrb_in[0];
		end
		case (st.wst)
			ASC_W_IDLE: begin
				if (do_write) begin
					next_st.aw_held = 1'b0;
					next_st.w_held = 1'b0;
					next_st.wst = ASC_W_RESP;
					next_st.bresp = (wr_flags || wr_ctrl || wr_mask ||
						!st.wstrb0) ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
					if (!st.wstrb0 && wr_word != `ASC_OFS_CTRL &&
						wr_word != `ASC_OFS_IRQ_MASK &&
						wr_word != `ASC_OFS_FLAGS)
						next_st.bresp = `ASC_RESP_SLVERR;
				end
			end
			ASC_W_RESP: begin
				if (s_axi_bready_in)
					next_st.wst = ASC_W_IDLE;
			end
			default: next_st.wst = ASC_W_IDLE;
		endcase
		// flag clears first so a same-cycle set wins below
		if (wr_flags) begin
			if (st.wdata[`ASC_BIT_DONE])
				next_st.flags.conv_done_flag = 1'b0;
			if (st.wdata[`ASC_BIT_PEN])
				next_st.flags.pen_down_flag = 1'b0;
			if (st.wdata[`ASC_BIT_UPD])
				next_st.flags.touch_data_update_flag = 1'b0;
		end
		if (conv_done_in)
			next_st.flags.conv_done_flag = 1'b1;
		if (pen_down_in)
			next_st.flags.pen_down_flag = 1'b1;
		if (touch_data_update_in)
			next_st.flags.touch_data_update_flag = 1'b1;
		if (wr_mask) begin
			next_st.mask = st.wdata[`ASC_BIT_DONE:`ASC_BIT_UPD];
		end
		if (wr_ctrl) begin
			next_st.ctrl.ref_handover_enable = st.wdata[`ASC_BIT_HAND];
			next_st.ctrl.ref_supply_switch = st.wdata[`ASC_BIT_REF];
			next_st.ctrl.input_channel_select =
				st.wdata[`ASC_CHS_HI:`ASC_CHS_LO];
			if (st.wdata[`ASC_BIT_START]) begin
				next_st.start = 1'b1;
				next_st.start_chan = st.wdata[`ASC_CHS_HI:`ASC_CHS_LO];
			end
		end
		if (do_read) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_val;
			next_st.rresp = rd_hit ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
		end else if (st.rvalid && s_axi_rready_in) begin
			next_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			st <= '0;
			st.wst <= ASC_W_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign conv_start_trigger_out = st.start;
	assign conv_channel_out = st.start ? st.start_chan :
		st.ctrl.input_channel_select;
	asc_chan_dec u_dec (
		.code_in(st.ctrl.input_channel_select),
		.onehot_out(channel_onehot_out)
	);
	assign converter_reference_supply_out = st.ctrl.ref_handover_enable ?
		touch_ref_request_in : st.ctrl.ref_supply_switch;
	assign ref_handover_enable_out = st.ctrl.ref_handover_enable;
	// level irq while any unmasked flag stands
	assign irq_out = |(st.flags & st.mask);

	sequence seq_ctrl_write_start;
		wr_ctrl && st.wdata[`ASC_BIT_START];
	endsequence

	AST_DONE_SETS: assert property (@(posedge core_clk_in) disable iff (srst_in)
		conv_done_in |=> st.flags.conv_done_flag)
		else $error("done flag not set");
	// write-one clears only if no new event
	AST_DONE_CLR: assert property (@(posedge core_clk_in) disable iff (srst_in)
		wr_flags && st.wdata[`ASC_BIT_DONE] && !conv_done_in
		|=> !st.flags.conv_done_flag)
		else $error("done flag not cleared");
	AST_PEN_HOLD: assert property (@(posedge core_clk_in) disable iff (srst_in)
		st.flags.pen_down_flag && !wr_flags |=> st.flags.pen_down_flag)
		else $error("pen flag lost");
	AST_UPD_SETS: assert property (@(posedge core_clk_in) disable iff (srst_in)
		touch_data_update_in |=> st.flags.touch_data_update_flag)
		else $error("update flag not set");
	AST_START_PULSE: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		seq_ctrl_write_start |=> conv_start_trigger_out ##1
		!conv_start_trigger_out)
		else $error("start pulse wrong");
	AST_START_CHAN: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		conv_start_trigger_out |->
		conv_channel_out == st.ctrl.input_channel_select)
		else $error("start channel mismatch");
	AST_DEC: assert property (@(posedge core_clk_in) disable iff (srst_in)
		channel_onehot_out == (8'h01 << st.ctrl.input_channel_select))
		else $error("channel decode wrong");
	// reference follows switch when not handed over
	AST_REF: assert property (@(posedge core_clk_in) disable iff (srst_in)
		!ref_handover_enable_out |->
		converter_reference_supply_out == st.ctrl.ref_supply_switch)
		else $error("reference supply wrong");
	AST_CHS_HOLD: assert property (@(posedge core_clk_in)
		disable iff (srst_in)
		!wr_ctrl |=> $stable(st.ctrl.input_channel_select))
		else $error("channel changed unwritten");
endmodule

// ---- tb/asc_adc_model.sv ----
module asc_adc_model (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic start_in,
	input wire logic [2:0] chan_in,
	input wire logic [4:0] lat_in,
	output logic done_out,
	output logic [2:0] last_chan_out,
	output logic [7:0] starts_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [5:0] cnt;
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		if (srst_in) begin
			cnt <= 6'h00;
			starts_out <= 8'h00;
			last_chan_out <= 3'h0;
		end else if (start_in) begin
			cnt <= {1'b0, lat_in} + 6'h01;
			last_chan_out <= chan_in;
			starts_out <= starts_out + 8'h01;
		end else if (cnt != 6'h00) begin
			cnt <= cnt - 6'h01;
			if (cnt == 6'h01) begin
				done_out <= 1'b1;
			end
		end
	end
endmodule

// ---- tb/asc_ctrl_tb.sv ----
`include "asc_cfg.svh"
module asc_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, srst, awv, wv, bready, arv, rready, done, pen, upd, treq;
	logic awr, wr_, bv, arr, rv, start, ref_out, hand, irq;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [2:0] chan, mchan, c;
	logic [7:0] onehot, starts;
	logic [4:0] lat;
	logic r;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int fail_count = 0, checked = 0, cyc = 0;
	asc_ctrl dut (.core_clk_in(clk), .srst_in(srst),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr_), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
		.s_axi_rready_in(rready), .conv_done_in(done),
		.pen_down_in(pen), .touch_data_update_in(upd),
		.touch_ref_request_in(treq), .conv_start_trigger_out(start),
		.conv_channel_out(chan), .channel_onehot_out(onehot),
		.converter_reference_supply_out(ref_out),
		.ref_handover_enable_out(hand), .irq_out(irq));
	asc_adc_model adc (.clk_in(clk), .srst_in(srst), .start_in(start),
		.chan_in(chan), .lat_in(lat), .done_out(done),
		.last_chan_out(mchan), .starts_out(starts));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task chk(input logic [33:0] e, input logic [33:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// one write or read in flight; ready sampled at the rising edge
	task wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] e);
		logic pa, pw, pb;
		@(posedge clk);
		bq.push_back(e);
		awaddr <= {a, 2'b00};
		wdata <= {24'h000000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		while (pb) begin
			@(posedge clk);
			if (awr && pa) begin
				awv <= 1'b0;
				pa = 1'b0;
			end
			if (wr_ && pw) begin
				wv <= 1'b0;
				pw = 1'b0;
			end
			if (bv) begin
				bready <= 1'b0;
				pb = 1'b0;
			end
		end
	endtask
	task rd(input logic [15:0] a, input logic [33:0] e);
		@(posedge clk);
		rq.push_back(e);
		araddr <= {a, 2'b00};
		arv <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		do @(posedge clk); while (!rv);
		rready <= 1'b0;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			complete_run();
		end
		if (bv && bready) chk({32'h0, bq.pop_front()}, {32'h0, bresp});
		// data not defined on an error answer
		if (rv && rready) begin
			if (rq[0][33:32] == 2'h0) chk(rq.pop_front(), {rresp, rdata});
			else chk(rq.pop_front(), {rresp, 32'h0});
		end
	end
	initial begin
		{srst, awv, wv, bready, arv, rready, pen, upd, treq} = 9'h1FF & 9'h100;
		awaddr = 18'h00000;
		araddr = 18'h00000;
		wdata = 32'h0;
		lat = 5'h00;
		void'($urandom(99));
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		rd(`ASC_OFS_FLAGS, 34'h0);
		rd(`ASC_OFS_CTRL, 34'h0);
		chk({32'h0, ref_out, hand}, 34'h0);
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			r = 1'($urandom % 2);
			lat <= 5'($urandom % 16);
			wr(`ASC_OFS_CTRL, {4'h8, r, c}, 2'h0);
			chk({22'h0, onehot, chan, r}, {22'h0, 8'h01 << c, c, ref_out});
			rd(`ASC_OFS_CTRL, {26'h0, 4'h0, r, c});
			repeat (24) @(posedge clk);
			chk({23'h0, starts, mchan}, {23'h0, 8'(i + 1), c});
			wr(`ASC_OFS_FLAGS, 8'h7F, 2'h0);
			rd(`ASC_OFS_FLAGS, 34'h80);
			wr(`ASC_OFS_FLAGS, 8'h80, 2'h0);
			rd(`ASC_OFS_FLAGS, 34'h0);
		end
		pen <= 1'b1;
		@(posedge clk) pen <= 1'b0;
		upd <= 1'b1;
		@(posedge clk) upd <= 1'b0;
		rd(`ASC_OFS_FLAGS, 34'h60);
		wr(`ASC_OFS_IRQ_MASK, 8'hE0, 2'h0);
		chk({33'h0, irq}, 34'h1);
		wr(`ASC_OFS_FLAGS, 8'h40, 2'h0);
		rd(`ASC_OFS_FLAGS, 34'h20);
		wr(`ASC_OFS_IRQ_MASK, 8'h00, 2'h0);
		chk({33'h0, irq}, 34'h0);
		wr(`ASC_OFS_FLAGS, 8'h20, 2'h0);
		rd(`ASC_OFS_FLAGS, 34'h0);
		wr(`ASC_OFS_CTRL, 8'h10, 2'h0);
		treq <= 1'b1;
		repeat (2) @(posedge clk);
		chk({32'h0, ref_out, hand}, 34'h3);
		treq <= 1'b0;
		repeat (2) @(posedge clk);
		chk({32'h0, ref_out, hand}, 34'h1);
		rd(`ASC_OFS_CTRL, 34'h10);
		wr(16'h0100, 8'h55, 2'h2);
		rd(16'h0100, {2'h2, 32'h0});
		repeat (4) @(posedge clk);
		complete_run();
	end
endmodule
